// ==== core/serial_port_pkg.sv ====
// shared constants for the clocked serial byte port and its far end
package serial_port_pkg;
  localparam int         BYTE_BITS      = 8;
  localparam int         MODE_W         = 4;
  // mode register field positions
  localparam int         MODE_CLK_SRC   = 0;
  localparam int         MODE_PORT_FN   = 1;
  localparam int         MODE_DIV_SEL   = 2;
  localparam logic [3:0] MODE_RESET     = 4'h0;
  localparam logic [7:0] SHIFT_RESET    = 8'h00;
  // serial clock period in instruction clocks, and last half-period count
  localparam int         DIV_SLOW       = 8;
  localparam int         DIV_FAST       = 4;
  localparam logic [2:0] HALF_SLOW_LAST = 3'(DIV_SLOW / 2 - 1);
  localparam logic [2:0] HALF_FAST_LAST = 3'(DIV_FAST / 2 - 1);
  localparam logic [2:0] LAST_BIT       = 3'(BYTE_BITS - 1);
  // ref clocks per instruction clock at the device end
  localparam int         INSTR_DIV_DEF  = 4;
  // ref clocks per half serial clock at the far end
  localparam int         FAR_HALF_DEF   = 8;
  // far-end register offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_TX         = 8'h04;
  localparam logic [7:0] OFS_RX         = 8'h08;
  localparam logic [7:0] OFS_STAT       = 8'h0C;
  localparam logic [7:0] OFS_MASK       = 8'h10;
  // far-end control and status bits
  localparam int         CTRL_START     = 0;
  localparam int         CTRL_CLK_MST   = 1;
  localparam int         CTRL_WAIT_RDY  = 2;
  localparam int         CTRL_ARM       = 3;
  localparam int         CTRL_BUSY      = 4;
  localparam int         STAT_DONE      = 0;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN  = 2'b10
  } xfer_state_type;
endpackage

// ==== core/serial_link_if.sv ====
// serial link between the device end and the far end, with pulled-up lines
`timescale 1ns/1ps
interface serial_link_if;
  logic dev_sck_o;
  logic dev_sck_oe;
  logic far_sck_o;
  logic far_sck_oe;
  logic dev_serial_out_pin;
  logic far_serial_out_pin;
  logic dev_rdy_o;
  logic dev_rdy_oe;
  logic far_rdy_o;
  logic far_rdy_oe;
  logic sck;
  logic rdy;
  logic dev_sin;
  logic far_sin;

  // wired lines idle high through the pull-up
  assign sck     = (dev_sck_oe ? dev_sck_o : 1'h1) & (far_sck_oe ? far_sck_o : 1'h1);
  assign rdy     = (dev_rdy_oe ? dev_rdy_o : 1'h1) & (far_rdy_oe ? far_rdy_o : 1'h1);
  assign dev_sin = far_serial_out_pin;
  assign far_sin = dev_serial_out_pin;

  modport dev (
    output dev_sck_o, dev_sck_oe, dev_serial_out_pin, dev_rdy_o, dev_rdy_oe,
    input  sck, rdy, dev_sin
  );
  modport far (
    output far_sck_o, far_sck_oe, far_serial_out_pin, far_rdy_o, far_rdy_oe,
    input  sck, rdy, far_sin
  );
endinterface

// ==== core/serial_port_far.sv ====
// far-end controller: axi4-lite registers driving a serial byte engine
`timescale 1ns/1ps
module serial_port_far
  import serial_port_pkg::*;
#(
  parameter int FAR_HALF = FAR_HALF_DEF
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  serial_link_if.far      link,
  input  wire logic       i_axi_awvalid,
  output logic            o_axi_awready,
  input  wire logic [7:0] i_axi_awaddr,
  input  wire logic       i_axi_wvalid,
  output logic            o_axi_wready,
  input  wire logic [31:0] i_axi_wdata,
  input  wire logic [3:0] i_axi_wstrb,
  output logic            o_axi_bvalid,
  input  wire logic       i_axi_bready,
  output logic [1:0]      o_axi_bresp,
  input  wire logic       i_axi_arvalid,
  output logic            o_axi_arready,
  input  wire logic [7:0] i_axi_araddr,
  output logic            o_axi_rvalid,
  input  wire logic       i_axi_rready,
  output logic [31:0]     o_axi_rdata,
  output logic [1:0]      o_axi_rresp,
  output logic            o_irq
);
  logic [2:0] sck_s, sin_s, rdy_s;
  logic sck_seen, next_sck_seen, rdy_seen, next_rdy_seen;
  logic aw_got, next_aw_got, w_got, next_w_got;
  logic [7:0] aw_addr, next_aw_addr, w_byte, next_w_byte;
  logic       next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [3:0] ctrl, next_ctrl;
  logic [7:0] tx, next_tx, rx, next_rx, shift, next_shift;
  logic stat, next_stat, mask, next_mask, next_irq;
  xfer_state_type state, next_state;
  logic [2:0] bitcnt, next_bitcnt;
  logic [7:0] hcnt, next_hcnt;
  logic sck_o, next_sck_o, serial_out_pin, next_serial_out_pin, rdy_o, next_rdy_o;

  // pin inputs pass three flops before use
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sck_s <= 3'h7;
      sin_s <= 3'h7;
      rdy_s <= 3'h7;
    end else begin
      sck_s <= {sck_s[1:0], link.sck};
      sin_s <= {sin_s[1:0], link.far_sin};
      rdy_s <= {rdy_s[1:0], link.rdy};
    end
  end

  always_comb begin
    logic mst, chg, rise, fall, tick, done, do_wr, start;
    logic [7:0] wa;
    next_aw_got = aw_got;  next_w_got = w_got;  next_aw_addr = aw_addr;
    next_w_byte = w_byte;  next_bvalid = o_axi_bvalid;  next_bresp = o_axi_bresp;
    next_rvalid = o_axi_rvalid;  next_rdata = o_axi_rdata;  next_rresp = o_axi_rresp;
    next_ctrl = ctrl;  next_tx = tx;  next_rx = rx;  next_shift = shift;
    next_stat = stat;  next_mask = mask;  next_state = state;  next_bitcnt = bitcnt;
    next_hcnt = hcnt;  next_sck_o = sck_o;  next_serial_out_pin = serial_out_pin;  next_rdy_o = rdy_o;
    next_sck_seen = (sck_s[1] == sck_s[2]) ? sck_s[2] : sck_seen;
    next_rdy_seen = (rdy_s[1] == rdy_s[2]) ? rdy_s[2] : rdy_seen;
    start = 1'h0;
    done  = 1'h0;
    // write address and data taken in either order
    if (i_axi_awvalid && o_axi_awready) begin
      next_aw_got  = 1'h1;
      next_aw_addr = i_axi_awaddr;
    end
    if (i_axi_wvalid && o_axi_wready) begin
      next_w_got  = 1'h1;
      next_w_byte = i_axi_wstrb[0] ? i_axi_wdata[7:0] : 8'h00;
    end
    if (o_axi_bvalid && i_axi_bready) next_bvalid = 1'h0;
    do_wr = next_aw_got && next_w_got && !o_axi_bvalid;
    wa    = next_aw_addr;
    if (do_wr) begin
      next_aw_got = 1'h0;
      next_w_got  = 1'h0;
      next_bvalid = 1'h1;
      next_bresp  = RESP_OKAY;
      case (wa)
        OFS_CTRL: begin
          next_ctrl = next_w_byte[3:0] & 4'hE;
          start     = next_w_byte[CTRL_START] && (state == ST_IDLE);
        end
        OFS_TX:   next_tx   = next_w_byte;
        OFS_MASK: next_mask = next_w_byte[STAT_DONE];
        default:  next_bresp = RESP_SLVERR;
      endcase
    end
    mst = ctrl[CTRL_CLK_MST];
    // own clock edges when master, filtered pin edges otherwise
    tick = mst && (state == ST_RUN) && (hcnt == 8'(FAR_HALF - 1));
    chg  = (next_sck_seen != sck_seen);
    rise = mst ? (tick && !sck_o) : (chg && next_sck_seen);
    fall = mst ? (tick && sck_o) : (chg && !next_sck_seen);
    if (state == ST_RUN && mst) next_hcnt = tick ? 8'h00 : hcnt + 8'h01;
    if (tick) next_sck_o = !sck_o;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_shift  = next_tx;   // byte loaded before any wait
          next_serial_out_pin   = next_tx[0];
          next_bitcnt = 3'h0;
          next_hcnt   = 8'h00;
          next_state  = next_w_byte[CTRL_WAIT_RDY] ? ST_WAIT : ST_RUN;
          if (next_w_byte[CTRL_ARM]) next_rdy_o = 1'h0;   // armed, now ready
        end
      end
      ST_WAIT: if (!rdy_seen) next_state = ST_RUN;   // receiver reports ready
      ST_RUN: begin
        if (fall) next_serial_out_pin = shift[0];
        if (rise) begin
          next_shift  = {sin_s[2], shift[7:1]};
          next_bitcnt = bitcnt + 3'h1;
          if (bitcnt == LAST_BIT) begin
            done        = 1'h1;
            next_rx     = {sin_s[2], shift[7:1]};
            next_rdy_o  = 1'h1;   // busy again before data is handled
            next_state  = ST_IDLE;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // reads; a status read clears it but a new event wins
    if (i_axi_arvalid && o_axi_arready) begin
      next_rvalid = 1'h1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      case (i_axi_araddr)
        OFS_CTRL: next_rdata[4:0] = {state != ST_IDLE, ctrl};
        OFS_TX:   next_rdata[7:0] = tx;
        OFS_RX:   next_rdata[7:0] = rx;
        OFS_STAT: begin
          next_rdata[STAT_DONE] = stat;
          next_stat             = 1'h0;
        end
        OFS_MASK: next_rdata[STAT_DONE] = mask;
        default:  next_rresp = RESP_SLVERR;
      endcase
    end else if (o_axi_rvalid && i_axi_rready) begin
      next_rvalid = 1'h0;
    end
    if (done) next_stat = 1'h1;
    next_irq     = next_stat && next_mask;
    next_awready = !next_aw_got && !next_bvalid;
    next_wready  = !next_w_got && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_got <= 1'h0;  w_got <= 1'h0;  aw_addr <= 8'h00;  w_byte <= 8'h00;
      o_axi_awready <= 1'h0;  o_axi_wready <= 1'h0;  o_axi_bvalid <= 1'h0;
      o_axi_bresp <= RESP_OKAY;  o_axi_arready <= 1'h0;  o_axi_rvalid <= 1'h0;
      o_axi_rdata <= 32'h0000_0000;  o_axi_rresp <= RESP_OKAY;  o_irq <= 1'h0;
      ctrl <= 4'h0;  tx <= 8'h00;  rx <= 8'h00;  shift <= SHIFT_RESET;
      stat <= 1'h0;  mask <= 1'h0;  state <= ST_IDLE;  bitcnt <= 3'h0;
      hcnt <= 8'h00;  sck_o <= 1'h1;  serial_out_pin <= 1'h1;  rdy_o <= 1'h1;
      sck_seen <= 1'h1;  rdy_seen <= 1'h1;
    end else begin
      aw_got <= next_aw_got;  w_got <= next_w_got;  aw_addr <= next_aw_addr;
      w_byte <= next_w_byte;  o_axi_awready <= next_awready;
      o_axi_wready <= next_wready;  o_axi_bvalid <= next_bvalid;
      o_axi_bresp <= next_bresp;  o_axi_arready <= next_arready;
      o_axi_rvalid <= next_rvalid;  o_axi_rdata <= next_rdata;
      o_axi_rresp <= next_rresp;  o_irq <= next_irq;
      ctrl <= next_ctrl;  tx <= next_tx;  rx <= next_rx;  shift <= next_shift;
      stat <= next_stat;  mask <= next_mask;  state <= next_state;
      bitcnt <= next_bitcnt;  hcnt <= next_hcnt;  sck_o <= next_sck_o;
      serial_out_pin <= next_serial_out_pin;  rdy_o <= next_rdy_o;
      sck_seen <= next_sck_seen;  rdy_seen <= next_rdy_seen;
    end
  end

  // link drives come straight from flops
  assign link.far_sck_o  = sck_o;   // idles high
  assign link.far_sck_oe = ctrl[CTRL_CLK_MST];
  assign link.far_serial_out_pin   = serial_out_pin;
  assign link.far_rdy_o  = rdy_o;
  assign link.far_rdy_oe = ctrl[CTRL_ARM];
endmodule

// ==== core/serial_port_dev.sv ====
// device end: instruction-driven clocked serial byte port
`timescale 1ns/1ps
// Behaviour
// - done flag sets when byte finishes
// - interrupt accept or skip test clears flag
// - start clears flag, then shifting begins
// - interrupt control picks interrupt or polling
// - mode register written and read via accumulator
// - external clock shifts every pulse, ungated
// - internal clock stops after byte completes
// - external mode: flag after eight pulses
// - external clock idles high before transfer
// - receiver holds ready high, arms, drives low
// - transmitter loads byte, waits ready low
// - receiver raises ready before processing byte
// - each further byte repeats from ready step
// - send from bit 0, receive into bit 7
// - low accumulator low nibble, second high
// - mode bit0 clock source, bit2 divide ratio
module serial_port_dev
  import serial_port_pkg::*;
#(
  parameter int INSTR_DIV = INSTR_DIV_DEF
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  serial_link_if.dev       link,
  input  wire logic        i_start,
  input  wire logic        i_skip_test,
  input  wire logic        i_irq_ack,
  input  wire logic        i_irq_sel,
  input  wire logic        i_load_mode,
  input  wire logic        i_load_shift,
  input  wire logic [3:0]  i_acc,
  input  wire logic [3:0]  i_acc_b,
  input  wire logic        i_ready_set,
  input  wire logic        i_ready_clr,
  output logic [3:0]       o_mode,
  output logic [7:0]       o_shift,
  output logic             o_skip,
  output logic             o_xfer_done_flag,
  output logic             o_irq,
  output logic             o_ready_in,
  output logic             o_busy
);
  logic [2:0] sck_s;
  logic [2:0] sin_s;
  logic [2:0] rdy_s;
  logic [7:0] icnt;
  logic [7:0] next_icnt;
  logic       instr_en;
  logic       next_instr_en;
  logic [3:0] serial_mode_reg;
  logic [3:0] next_mode;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic       xfer_done_flag;
  logic       next_flag;
  xfer_state_type state;
  xfer_state_type next_state;
  logic [2:0] bitcnt;
  logic [2:0] next_bitcnt;
  logic [2:0] hcnt;
  logic [2:0] next_hcnt;
  logic       sck_o;
  logic       next_sck_o;
  logic       sck_oe;
  logic       next_sck_oe;
  logic       serial_out_pin;
  logic       next_serial_out_pin;
  logic       sck_seen;
  logic       next_sck_seen;
  logic       ready_port_bit;
  logic       next_ready_port_bit;
  logic       ready_oe;
  logic       next_ready_oe;
  logic       rdy_seen;
  logic       next_rdy_seen;
  logic       next_skip;
  logic       next_irq;

  // pins from the far side pass three flops; only the last two are compared
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sck_s <= 3'h7;
      sin_s <= 3'h7;
      rdy_s <= 3'h7;
    end else begin
      sck_s <= {sck_s[1:0], link.sck};
      sin_s <= {sin_s[1:0], link.dev_sin};
      rdy_s <= {rdy_s[1:0], link.rdy};
    end
  end

  // instruction clock enable from the reference clock
  always_comb begin
    next_instr_en = (icnt == 8'(INSTR_DIV - 1));
    next_icnt     = next_instr_en ? 8'h00 : icnt + 8'h01;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      icnt     <= 8'h00;
      instr_en <= 1'h0;
    end else begin
      icnt     <= next_icnt;
      instr_en <= next_instr_en;
    end
  end

  // transfer engine, mode register, flag and ready port bit
  always_comb begin
    logic       int_clk;
    logic       port_on;
    logic [2:0] half_last;
    logic       tick;
    logic       chg;
    logic       rise;
    logic       fall;
    logic       done;
    int_clk     = serial_mode_reg[MODE_CLK_SRC];
    port_on     = serial_mode_reg[MODE_PORT_FN];
    half_last   = serial_mode_reg[MODE_DIV_SEL] ? HALF_FAST_LAST
                                                : HALF_SLOW_LAST;
    next_mode   = serial_mode_reg;
    next_shift  = shift;
    next_flag   = xfer_done_flag;
    next_state  = state;
    next_bitcnt = bitcnt;
    next_hcnt   = hcnt;
    next_sck_o  = sck_o;
    next_serial_out_pin   = serial_out_pin;
    next_ready_port_bit = ready_port_bit;
    next_ready_oe       = ready_oe;
    done        = 1'h0;
    // an edge counts once the second and third flops agree
    next_sck_seen = (sck_s[1] == sck_s[2]) ? sck_s[2] : sck_seen;
    next_rdy_seen = (rdy_s[1] == rdy_s[2]) ? rdy_s[2] : rdy_seen;
    chg  = (next_sck_seen != sck_seen);
    tick = int_clk && instr_en && (state == ST_RUN) && (hcnt == half_last);
    if (int_clk && instr_en && state == ST_RUN) begin
      next_hcnt = tick ? 3'h0 : hcnt + 3'h1;
    end
    if (tick) next_sck_o = !sck_o;
    // pulled-up external clock is high when idle, so first change is a fall
    rise = port_on && (int_clk ? (tick && !sck_o)
                               : (chg && next_sck_seen));
    fall = port_on && (int_clk ? (tick && sck_o)
                               : (chg && !next_sck_seen));
    if (i_load_mode) next_mode = i_acc;
    if (i_load_shift) begin
      next_shift = {i_acc_b, i_acc};
      next_serial_out_pin  = i_acc[0];
    end
    if (fall) next_serial_out_pin = shift[0];
    // an external clock shifts on every pulse, idle or not
    if (rise) next_shift = {sin_s[2], shift[7:1]};
    case (state)
      ST_IDLE: begin
        if (i_start) begin
          next_flag   = 1'h0;
          next_state  = ST_RUN;
          next_bitcnt = 3'h0;
          next_hcnt   = 3'h0;
          next_sck_o  = 1'h1;
          next_serial_out_pin   = shift[0];
        end
      end
      ST_RUN: begin
        if (rise) begin
          next_bitcnt = bitcnt + 3'h1;
          if (bitcnt == LAST_BIT) begin
            done       = 1'h1;
            next_state = ST_IDLE;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // interrupt accept or a successful skip test clears the flag
    if (i_irq_ack || (i_skip_test && xfer_done_flag)) next_flag = 1'h0;
    // completion in the same cycle as a clear is kept
    if (done) next_flag = 1'h1;
    next_skip = i_skip_test && xfer_done_flag;
    next_irq  = next_flag && i_irq_sel;
    // port bit carries the receive handshake; software sequences it
    if (i_ready_set) begin
      next_ready_port_bit = 1'h1;
      next_ready_oe       = 1'h1;
    end else if (i_ready_clr) begin
      next_ready_port_bit = 1'h0;
      next_ready_oe       = 1'h1;
    end
    next_sck_oe = next_mode[MODE_PORT_FN] && next_mode[MODE_CLK_SRC];
    // internal clock is forced high whenever no byte is moving
    if (next_state == ST_IDLE) next_sck_o = 1'h1;
    if (!next_mode[MODE_PORT_FN]) next_serial_out_pin = 1'h1;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      serial_mode_reg  <= MODE_RESET;
      shift            <= SHIFT_RESET;
      xfer_done_flag   <= 1'h0;
      state            <= ST_IDLE;
      bitcnt           <= 3'h0;
      hcnt             <= 3'h0;
      sck_o            <= 1'h1;
      sck_oe           <= 1'h0;
      serial_out_pin             <= 1'h1;
      sck_seen         <= 1'h1;
      rdy_seen         <= 1'h1;
      ready_port_bit   <= 1'h1;
      ready_oe         <= 1'h0;
      o_mode           <= MODE_RESET;
      o_shift          <= SHIFT_RESET;
      o_skip           <= 1'h0;
      o_xfer_done_flag <= 1'h0;
      o_irq            <= 1'h0;
      o_ready_in       <= 1'h1;
      o_busy           <= 1'h0;
    end else begin
      serial_mode_reg  <= next_mode;
      shift            <= next_shift;
      xfer_done_flag   <= next_flag;
      state            <= next_state;
      bitcnt           <= next_bitcnt;
      hcnt             <= next_hcnt;
      sck_o            <= next_sck_o;
      sck_oe           <= next_sck_oe;
      serial_out_pin             <= next_serial_out_pin;
      sck_seen         <= next_sck_seen;
      rdy_seen         <= next_rdy_seen;
      ready_port_bit   <= next_ready_port_bit;
      ready_oe         <= next_ready_oe;
      o_mode           <= next_mode;
      o_shift          <= next_shift;
      o_skip           <= next_skip;
      o_xfer_done_flag <= next_flag;
      o_irq            <= next_irq;
      // transmitter polls this before starting its byte
      o_ready_in       <= next_rdy_seen;
      o_busy           <= (next_state != ST_IDLE);
    end
  end

  // pin drives straight from flops
  assign link.dev_sck_o  = sck_o;
  assign link.dev_sck_oe = sck_oe;
  assign link.dev_serial_out_pin   = serial_out_pin;
  assign link.dev_rdy_o  = ready_port_bit;
  assign link.dev_rdy_oe = ready_oe;
endmodule

// ==== dv/serial_link_checker.sv ====
// link assertions for the serial byte port pair
`timescale 1ns/1ps
module serial_link_checker (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic dev_sck_o,
  input wire logic dev_sck_oe,
  input wire logic far_sck_o,
  input wire logic far_sck_oe,
  input wire logic dev_serial_out_pin,
  input wire logic sck,
  input wire logic rdy
);
  logic [4:0] gap;
  logic [4:0] next_gap;
  logic [3:0] falls;
  logic [3:0] next_falls;
  logic       sck_d;

  // a burst ends once sck stays high 31 cycles; longer than any half period
  always_comb begin
    next_gap   = !sck ? 5'h00 : (gap == 5'h1F) ? gap : gap + 5'h01;
    next_falls = ((gap == 5'h1F) ? 4'h0 : falls) + {3'h0, sck_d & !sck};
  end

  // gap and fall counters
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap   <= 5'h00;
      falls <= 4'h0;
      sck_d <= 1'h1;
    end else begin
      gap   <= next_gap;
      falls <= next_falls;
      sck_d <= sck;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // low half is 8 or 16 cycles at the bench divider
  sequence s_low_half;
    !dev_sck_o [*3] ##[1:14] dev_sck_o;
  endsequence

  a_dev_idle_high: assert property ($rose(dev_sck_oe) |-> dev_sck_o)
    else $error("device clock enabled low");
  a_far_idle_high: assert property ($rose(far_sck_oe) |-> far_sck_o)
    else $error("far clock enabled low");
  a_dev_half_low: assert property (dev_sck_oe && $fell(dev_sck_o) |-> s_low_half)
    else $error("device clock low phase wrong");
  a_burst_max: assert property (falls <= 4'h8)
    else $error("more than eight pulses");
  a_burst_whole: assert property (gap == 5'h1E |-> falls == 4'h0 || falls == 4'h8)
    else $error("burst not eight pulses");
  a_dev_data_hold: assert property ($rose(sck) |=> $stable(dev_serial_out_pin) [*2])
    else $error("device data moved after rise");
  a_far_waits_ready: assert property (far_sck_oe && $fell(far_sck_o) |-> !rdy)
    else $error("far clocked while not ready");
  a_ready_rise_idle: assert property ($rose(rdy) |-> sck)
    else $error("ready raised mid byte");
  a_ready_before_clk: assert property ($fell(rdy) |-> sck [*3])
    else $error("ready dropped mid byte");
endmodule

// ==== dv/clocked_serial_byte_port_bench.sv ====
// self-checking bench: device end and far end joined over the link
`timescale 1ns/1ps
`define chk(got, exp) begin checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module clocked_serial_byte_port_bench;
  import serial_port_pkg::*;
  localparam logic [31:0] RX_GO = (32'h1 << CTRL_ARM) | (32'h1 << CTRL_START);
  localparam logic [31:0] TX_GO = (32'h1 << CTRL_START) | (32'h1 << CTRL_CLK_MST)
                                  | (32'h1 << CTRL_WAIT_RDY);
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [6:0]  op = 7'h00;
  logic        irq_sel = 1'b0;
  logic [3:0]  acc = 4'h0;
  logic [3:0]  acc_b = 4'h0;
  logic [3:0]  mode;
  logic [7:0]  shift;
  logic        skip, flag, irq, ready_in, busy, far_irq;
  logic        awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
  logic        arvalid = 1'b0, arready, rvalid, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  logic [31:0] seed = 32'h000177E4;
  int          n_fail = 0, checked = 0, n_skip = 0;
  serial_link_if link ();

  // 125 MHz reference clock
  always #4 clk = ~clk;
  // skip pulses are one cycle wide, so count them where they stand
  always @(posedge clk) if (skip === 1'b1) n_skip++;

  serial_port_dev #(.INSTR_DIV(INSTR_DIV_DEF)) serial_port_dev_i (.i_ref_clk(clk),
    .i_rst_n(rst_n), .link(link), .i_start(op[0]), .i_skip_test(op[1]), .i_irq_ack(op[2]),
    .i_irq_sel(irq_sel),
    .i_load_mode(op[3]), .i_load_shift(op[4]), .i_acc(acc), .i_acc_b(acc_b),
    .i_ready_set(op[5]), .i_ready_clr(op[6]), .o_mode(mode), .o_shift(shift), .o_skip(skip),
    .o_xfer_done_flag(flag), .o_irq(irq), .o_ready_in(ready_in), .o_busy(busy));
  serial_port_far serial_port_far_i (.i_ref_clk(clk), .i_rst_n(rst_n), .link(link),
    .i_axi_awvalid(awvalid), .o_axi_awready(awready), .i_axi_awaddr(awaddr),
    .i_axi_wvalid(wvalid), .o_axi_wready(wready), .i_axi_wdata(wdata), .i_axi_wstrb(4'hF),
    .o_axi_bvalid(bvalid), .i_axi_bready(bready), .o_axi_bresp(bresp), .i_axi_arvalid(arvalid),
    .o_axi_arready(arready), .i_axi_araddr(araddr), .o_axi_rvalid(rvalid),
    .i_axi_rready(rready), .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_irq(far_irq));
  serial_link_checker serial_link_checker_i (.i_ref_clk(clk), .i_rst_n(rst_n),
    .dev_sck_o(link.dev_sck_o), .dev_sck_oe(link.dev_sck_oe), .far_sck_o(link.far_sck_o),
    .far_sck_oe(link.far_sck_oe), .dev_serial_out_pin(link.dev_serial_out_pin), .sck(link.sck), .rdy(link.rdy));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // expected shift register after a nibble-pair load
  function automatic logic [7:0] pack_pair(input logic [3:0] lo, input logic [3:0] hi);
    return {hi, lo};
  endfunction

  task automatic print_verdict();
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // one-cycle instruction pulse; trailing edge keeps drives a step apart
  task automatic do_op(input int b);
    op[b] <= 1'b1;
    @(posedge clk);
    op <= 7'h00;
    @(posedge clk);
  endtask

  // bounded wait on the done flag (sel 0) or the ready input (sel 1)
  task automatic wait_for(input bit sel, input logic lvl);
    int k;
    k = 0;
    while (k < 4000 && (sel ? ready_in : flag) !== lvl) begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // each channel is released at the edge that takes it
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    bready <= 1'b0;
    `chk(bresp, er)
    @(posedge clk);
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    `chk(rdata, ed)
    `chk(rresp, er)
    @(posedge clk);
  endtask

  // main sequence: reset, mode table, then alternating byte exchanges
  initial begin
    logic [7:0] tx_dev, tx_far;
    logic       ext, mask_on;
    int         n0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `chk(mode, MODE_RESET)
    `chk(flag, 1'b0)
    for (int m = 0; m < 16; m++) begin
      acc <= 4'(m);
      do_op(3);
      `chk(mode, 4'(m))
    end
    axi_write(8'h20, 32'h0, RESP_SLVERR);
    axi_read(8'h20, 32'h0, RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      seed = xorshift(seed);
      ext = i[0];
      tx_dev = (i == 0) ? 8'h01 : seed[7:0];
      tx_far = (i == 0) ? 8'h80 : seed[15:8];
      mask_on = seed[16];
      irq_sel <= seed[17];
      axi_write(OFS_MASK, {31'h0, mask_on}, RESP_OKAY);
      axi_write(OFS_TX, {24'h0, tx_far}, RESP_OKAY);
      if (!ext) axi_write(OFS_CTRL, RX_GO, RESP_OKAY);
      acc <= ext ? 4'h2 : {1'b0, i[1], 2'h3};
      do_op(3);
      acc <= tx_dev[3:0];
      acc_b <= tx_dev[7:4];
      do_op(4);
      `chk(shift, pack_pair(tx_dev[3:0], tx_dev[7:4]))
      if (ext) begin
        do_op(5);
        do_op(0);
        axi_write(OFS_CTRL, TX_GO, RESP_OKAY);
        do_op(6);
      end else begin
        wait_for(1, 1'b0);
        do_op(0);
      end
      `chk(flag, 1'b0)
      `chk(busy, 1'b1)
      wait_for(0, 1'b1);
      `chk(flag, 1'b1)
      if (ext) do_op(5);
      repeat (20) @(posedge clk);
      `chk(link.sck, 1'b1)
      `chk(busy, 1'b0)
      `chk(shift, tx_far)
      `chk(irq, irq_sel)
      `chk(far_irq, mask_on)
      axi_read(OFS_STAT, 32'h1, RESP_OKAY);
      `chk(far_irq, 1'b0)
      axi_read(OFS_RX, {24'h0, tx_dev}, RESP_OKAY);
      wait_for(1, 1'b1);
      `chk(ready_in, 1'b1)
      n0 = n_skip;
      case (seed[20:19])
        2'h0: begin
          do_op(1);
          do_op(1);
          `chk(n_skip - n0, 1)
        end
        2'h1: do_op(2);
        default: ;
      endcase
      `chk(flag, seed[20])
    end
    print_verdict();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule
